/* include/ioss_defs.svh */
`ifndef IOSS_DEFS_SVH
`define IOSS_DEFS_SVH

// register byte offsets
`define IOSS_OFF_STATE      8'h00
`define IOSS_OFF_EVENT      8'h04
`define IOSS_OFF_MASK       8'h08

// event / mask bit positions
`define IOSS_EV_FLAG_SET    0
`define IOSS_EV_HALT_CLR    1
`define IOSS_EV_START_CLR   2
`define IOSS_EV_W           3

// reset values
`define IOSS_MASK_RST       3'h0
`define IOSS_WORD_RST       32'h0000_0000

// state register bit positions
`define IOSS_ST_FLAG        0
`define IOSS_ST_IO_LINE     1
`define IOSS_ST_DOR_LINE    2
`define IOSS_ST_END_DATA    3
`define IOSS_ST_CHAN_END    4
`define IOSS_ST_UNUS_END    5
`define IOSS_ST_BUSY_CLR    6

// positions of the pin inputs in the synchronised bundle
`define IOSS_I_REQ          0
`define IOSS_I_FS           1
`define IOSS_I_FACK         2
`define IOSS_I_ADDR         3
`define IOSS_I_SIO          4
`define IOSS_I_HIO          5
`define IOSS_I_TIO          6
`define IOSS_I_TDV          7
`define IOSS_I_ACK_INTERRUPT_CYCLE         8
`define IOSS_I_INTP         9
`define IOSS_I_READY        10
`define IOSS_I_OIN_ARM      11
`define IOSS_I_TERM         12
`define IOSS_I_OIN          13
`define IOSS_I_OOUT         14
`define IOSS_I_CONN         15
`define IOSS_I_B2           16
`define IOSS_I_ESR          17
`define IOSS_I_W            18

`endif

/* include/ioss_pkg.sv */
package ioss_pkg;

   typedef logic [31:0] ioss_word_t;

   typedef enum logic [1:0] {
      REG_STATE,
      REG_EVENT,
      REG_MASK,
      REG_NONE
   } ioss_reg_e;

endpackage : ioss_pkg

/* include/ioss_sync_if.sv */
`timescale 1ns/10ps
interface ioss_sync_if #(parameter int W = 18);
   logic [W-1:0] raw;
   logic [W-1:0] lvl;
   logic [W-1:0] fall;

   modport sync (input raw, output lvl, output fall);
   modport user (output raw, input lvl, input fall);
endinterface : ioss_sync_if

/* design/ioss_edge_sync.sv */
`timescale 1ns/10ps
module ioss_edge_sync #(
   parameter int W = 18
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // pin bundle
   ioss_sync_if.sync sif
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] fall_r;
   logic [W-1:0] lvl_nxt;

   // a change counts only once stages two and three agree
   always_comb begin
      lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= sif.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // strobe falling edges become one-cycle pulses on the system clock
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lvl_r  <= '0;
         fall_r <= '0;
      end else begin
         lvl_r  <= lvl_nxt;
         fall_r <= lvl_r & ~lvl_nxt;
      end
   end

   assign sif.lvl  = lvl_r;
   assign sif.fall = fall_r;
endmodule : ioss_edge_sync

/* design/ioss_state_status.sv */
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "ioss_defs.svh"
module ioss_state_status #(
   parameter int AW = 8
) (
   // clock and resets
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          sysReset,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   output logic               irq,
   // channel and controller pins
   input  wire logic          requestStrobe,
   input  wire logic          functionStrobeIn,
   input  wire logic          functionAckDrive,
   input  wire logic          addressMatch,
   input  wire logic          startIoCmd,
   input  wire logic          haltIoCmd,
   input  wire logic          testIoCmd,
   input  wire logic          testDeviceCmd,
   input  wire logic          ackInterruptCycle,
   input  wire logic          interruptPending,
   input  wire logic          deviceReady,
   input  wire logic          orderInArm,
   input  wire logic          terminalOrderFlag,
   input  wire logic          orderInState,
   input  wire logic          orderOutState,
   input  wire logic          serviceConnected,
   input  wire logic          secondByte,
   input  wire logic          endServiceIn,
   // drives toward the channel
   output logic               unusualEndFlag,
   output logic               ioIndicatorDrive,
   output logic               dataOrderIndicatorDrive,
   output logic               endDataDrive,
   output logic               channelEndDrive,
   output logic               unusualEndDrive,
   output logic               busyClear
);
   ioss_sync_if #(.W(`IOSS_I_W)) sif ();

   ioss_edge_sync #(.W(`IOSS_I_W)) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .sif   (sif)
   );

   assign sif.raw = {endServiceIn, secondByte, serviceConnected, orderOutState,
                     orderInState, terminalOrderFlag, orderInArm, deviceReady,
                     interruptPending, ackInterruptCycle, testDeviceCmd, testIoCmd,
                     haltIoCmd, startIoCmd, addressMatch, functionAckDrive,
                     functionStrobeIn, requestStrobe};

   logic reqFall;
   logic fsFall;
   logic ackFall;
   logic fs;
   logic adr;
   logic idle;
   logic noInt;
   logic conn;
   logic order_in_state;
   logic oout;

   assign reqFall = sif.fall[`IOSS_I_REQ];
   assign fsFall  = sif.fall[`IOSS_I_FS];
   assign ackFall = sif.fall[`IOSS_I_FACK];
   assign fs      = sif.lvl[`IOSS_I_FS];
   assign adr     = sif.lvl[`IOSS_I_ADDR];
   assign idle    = sif.lvl[`IOSS_I_READY];
   assign noInt   = ~sif.lvl[`IOSS_I_INTP];
   assign conn    = sif.lvl[`IOSS_I_CONN];
   assign order_in_state     = sif.lvl[`IOSS_I_OIN];
   assign oout    = sif.lvl[`IOSS_I_OOUT];

   // unusual-end flag
   logic flag_r;
   logic flagSet;
   logic haltClr;
   logic startClr;

   assign flagSet  = reqFall & sif.lvl[`IOSS_I_OIN_ARM] & sif.lvl[`IOSS_I_TERM] & ~flag_r;
   assign haltClr  = ackFall & sif.lvl[`IOSS_I_HIO] & adr;
   assign startClr = fsFall & sif.lvl[`IOSS_I_SIO] & adr & noInt & idle;

   // set beats a clear landing in the same cycle only while the flag is clear; with the flag already set the clear wins and the order-in entry is lost
   always_ff @(posedge clk or posedge sysReset) begin
      if (sysReset) begin
         flag_r <= 1'b0;
      end else if (!rst_b) begin
         flag_r <= 1'b0;
      end else if (flagSet) begin
         flag_r <= 1'b1;
      end else if (haltClr || startClr) begin
         flag_r <= 1'b0;
      end
   end

   assign unusualEndFlag = flag_r;

   // indicator, end data and status drives, all registered
   logic ioNxt;
   logic dorNxt;
   logic adrCmd;

   always_comb begin
      adrCmd = adr & (sif.lvl[`IOSS_I_SIO] | sif.lvl[`IOSS_I_HIO]
                    | sif.lvl[`IOSS_I_TIO] | sif.lvl[`IOSS_I_TDV]);
      dorNxt = (fs & adrCmd)
             | (fs & sif.lvl[`IOSS_I_ACK_INTERRUPT_CYCLE])
             | (conn & (oout | order_in_state));
      ioNxt  = (fs & adr & sif.lvl[`IOSS_I_TDV])
             | (fs & adr & sif.lvl[`IOSS_I_HIO] & idle)
             | (fs & adr & sif.lvl[`IOSS_I_TIO] & idle & noInt)
             | (fs & adr & sif.lvl[`IOSS_I_SIO] & idle & noInt)
             | (fs & sif.lvl[`IOSS_I_ACK_INTERRUPT_CYCLE])
             | (conn & oout);
   end

   logic io_r;
   logic dor_r;
   logic ed_r;
   logic ce_r;
   logic ue_r;
   logic busyClr_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         io_r      <= 1'b0;
         dor_r     <= 1'b0;
         ed_r      <= 1'b0;
         ce_r      <= 1'b0;
         ue_r      <= 1'b0;
         busyClr_r <= 1'b0;
      end else begin
         io_r      <= ioNxt;
         dor_r     <= dorNxt;
         ed_r      <= conn & (sif.lvl[`IOSS_I_B2] | order_in_state | oout);
         ce_r      <= flag_r & order_in_state;
         ue_r      <= flag_r & order_in_state;
         busyClr_r <= conn & sif.lvl[`IOSS_I_ESR] & flag_r;
      end
   end

   assign ioIndicatorDrive        = io_r;
   assign dataOrderIndicatorDrive = dor_r;
   assign endDataDrive            = ed_r;
   assign channelEndDrive         = ce_r;
   assign unusualEndDrive         = ue_r;
   assign busyClear               = busyClr_r;

   // event capture and interrupt
   logic [`IOSS_EV_W-1:0] event_r;
   logic [`IOSS_EV_W-1:0] mask_r;
   logic [`IOSS_EV_W-1:0] evHit;
   logic                  irq_r;
   logic                  wrEn;
   logic                  acc;
   ioss_pkg::ioss_reg_e   sel;

   function automatic ioss_pkg::ioss_reg_e decode(input logic [AW-1:0] a);
      unique case (a)
         `IOSS_OFF_STATE: decode = ioss_pkg::REG_STATE;
         `IOSS_OFF_EVENT: decode = ioss_pkg::REG_EVENT;
         `IOSS_OFF_MASK:  decode = ioss_pkg::REG_MASK;
         default:         decode = ioss_pkg::REG_NONE;
      endcase
   endfunction : decode

   assign sel   = decode(paddr);
   assign acc   = psel & penable & pready;
   assign wrEn  = acc & pwrite;
   assign evHit = {startClr, haltClr, flagSet};

   // write-one-to-clear; a new event in the same cycle stays set
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         event_r <= '0;
      end else if (wrEn && sel == ioss_pkg::REG_EVENT) begin
         event_r <= (event_r & ~pwdata[`IOSS_EV_W-1:0]) | evHit;
      end else begin
         event_r <= event_r | evHit;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_r <= `IOSS_MASK_RST;
      end else if (wrEn && sel == ioss_pkg::REG_MASK) begin
         mask_r <= pwdata[`IOSS_EV_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(event_r & mask_r);
      end
   end

   assign irq = irq_r;

   // apb answer: one wait cycle, then pready for one cycle
   ioss_pkg::ioss_word_t rd;

   always_comb begin
      rd = `IOSS_WORD_RST;
      unique case (sel)
         ioss_pkg::REG_STATE: begin
            rd[`IOSS_ST_FLAG]     = flag_r;
            rd[`IOSS_ST_IO_LINE]  = io_r;
            rd[`IOSS_ST_DOR_LINE] = dor_r;
            rd[`IOSS_ST_END_DATA] = ed_r;
            rd[`IOSS_ST_CHAN_END] = ce_r;
            rd[`IOSS_ST_UNUS_END] = ue_r;
            rd[`IOSS_ST_BUSY_CLR] = busyClr_r;
         end
         ioss_pkg::REG_EVENT: rd[`IOSS_EV_W-1:0] = event_r;
         ioss_pkg::REG_MASK:  rd[`IOSS_EV_W-1:0] = mask_r;
         ioss_pkg::REG_NONE:  rd = `IOSS_WORD_RST;
      endcase
   end

   logic                 pready_r;
   logic                 pslverr_r;
   ioss_pkg::ioss_word_t prdata_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= `IOSS_WORD_RST;
      end else begin
         pready_r  <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & (sel == ioss_pkg::REG_NONE);
         prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? rd : `IOSS_WORD_RST;
      end
   end

   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign prdata  = prdata_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence sSetCause;
      reqFall && sif.lvl[`IOSS_I_OIN_ARM] && sif.lvl[`IOSS_I_TERM] && !flag_r;
   endsequence

   sequence sOrderOut;
      conn && oout && !fs;
   endsequence

   sequence sOrderIn;
      conn && order_in_state && !oout && !fs;
   endsequence

   a_flag_set: assert property (sSetCause |=> flag_r)
      else $error("flag not set on armed strobe fall");
   a_sys_reset: assert property (@(posedge clk) sysReset |-> !flag_r)
      else $error("flag survives system reset");
   a_halt_clear: assert property (haltClr && !flagSet |=> !flag_r)
      else $error("halt did not clear flag");
   a_start_clear: assert property (startClr && !flagSet |=> !flag_r)
      else $error("start did not clear flag");
   a_status_byte: assert property (flag_r && order_in_state |=> ce_r && ue_r)
      else $error("status byte missing on order-in");
   a_status_quiet: assert property (!(flag_r && order_in_state) |=> !ce_r && !ue_r)
      else $error("status byte driven outside order-in");
   a_busy_clear: assert property (conn && sif.lvl[`IOSS_I_ESR] && flag_r |=> busyClr_r)
      else $error("busy not cleared");
   a_no_data_out: assert property (io_r |-> dor_r)
      else $error("data-out cycle requested");
   a_fn_dor: assert property (fs && adrCmd |=> dor_r)
      else $error("data-order line missing");
   a_aio_both: assert property (fs && sif.lvl[`IOSS_I_ACK_INTERRUPT_CYCLE] |=> io_r && dor_r)
      else $error("ack-interrupt lines missing");
   a_tdv_io: assert property (fs && adr && sif.lvl[`IOSS_I_TDV] |=> io_r)
      else $error("test-device io line missing");
   a_hio_busy: assert property (fs && adr && sif.lvl[`IOSS_I_HIO] && !idle
      && !sif.lvl[`IOSS_I_ACK_INTERRUPT_CYCLE] && !sif.lvl[`IOSS_I_TDV] && !sif.lvl[`IOSS_I_TIO]
      && !sif.lvl[`IOSS_I_SIO] && !conn |=> !io_r)
      else $error("halt io line while busy");
   a_tio_io: assert property (fs && adr && sif.lvl[`IOSS_I_TIO] && idle && noInt
      |=> io_r)
      else $error("test-io io line missing");
   a_svc_out: assert property (sOrderOut |=> io_r && dor_r && ed_r)
      else $error("order-out code wrong");
   a_svc_in: assert property (sOrderIn and !sif.lvl[`IOSS_I_ACK_INTERRUPT_CYCLE]
      |=> !io_r && dor_r && ed_r)
      else $error("order-in code wrong");
   a_sio_io: assert property (fs && adr && sif.lvl[`IOSS_I_SIO] && idle && noInt
      |=> io_r)
      else $error("start io line missing");
endmodule : ioss_state_status

/* verif/ioss_chan_model.sv */
`timescale 1ns/10ps
module ioss_chan_model (
   // clock
   input  wire logic clk,
   // channel drives
   output logic       functionStrobeIn,
   output logic       endServiceIn,
   output logic       terminalOrderFlag,
   output logic       ackInterruptCycle,
   output logic [3:0] cmd
);
   initial begin
      functionStrobeIn  = 1'b0;
      endServiceIn      = 1'b0;
      terminalOrderFlag = 1'b0;
      ackInterruptCycle = 1'b0;
      cmd               = 4'h0;
   end

   // command lines stay up while the strobe falls, so the fall is seen with its command
   task instr(input logic [4:0] c, input logic s);
      @(posedge clk);
      cmd               <= c[3:0];
      ackInterruptCycle <= c[4];
      functionStrobeIn  <= s;
   endtask : instr

   // end service held low until the terminal order, driven during its transfer
   task term_order(input logic on);
      @(posedge clk);
      terminalOrderFlag <= on;
      endServiceIn      <= on;
   endtask : term_order

   task end_service(input logic on);
      @(posedge clk);
      endServiceIn <= on;
   endtask : end_service
endmodule : ioss_chan_model

/* verif/tb_top.sv */
`timescale 1ns/10ps
`include "ioss_defs.svh"
module tb_top;
   typedef struct {string nm; logic [32:0] v;} ioss_note_s;
   logic        clk = 1'b0, rst_b = 1'b0, sysReset = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic        pready, pslverr, irq, fsIn, esIn, toFlag, ack_interrupt_cycle;
   logic        requestStrobe = 1'b0, functionAckDrive = 1'b0, addressMatch = 1'b0;
   logic        interruptPending = 1'b0, deviceReady = 1'b1, orderInArm = 1'b0;
   logic        orderInState = 1'b0, orderOutState = 1'b0, serviceConnected = 1'b0;
   logic        secondByte = 1'b0;
   logic        flag, ioInd, dorInd, endData, chEnd, unEnd, busyClr;
   logic [3:0]  chCmd;
   wire  [7:0]  obs = {busyClr, unEnd, chEnd, endData, dorInd, ioInd, flag, irq};
   ioss_note_s  notes[$];
   int          fail_count = 0, num_checks = 0;
   event        smp;

   always #50 clk = ~clk;

   ioss_chan_model u_ioss_chan_model (.clk(clk), .functionStrobeIn(fsIn), .endServiceIn(esIn),
      .terminalOrderFlag(toFlag), .ackInterruptCycle(ack_interrupt_cycle), .cmd(chCmd));
   ioss_state_status #(.AW(8)) u_ioss_state_status (.clk(clk), .rst_b(rst_b),
      .sysReset(sysReset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .requestStrobe(requestStrobe), .functionStrobeIn(fsIn),
      .functionAckDrive(functionAckDrive), .addressMatch(addressMatch),
      .startIoCmd(chCmd[0]), .haltIoCmd(chCmd[1]), .testIoCmd(chCmd[2]),
      .testDeviceCmd(chCmd[3]), .ackInterruptCycle(ack_interrupt_cycle), .interruptPending(interruptPending),
      .deviceReady(deviceReady), .orderInArm(orderInArm), .terminalOrderFlag(toFlag),
      .orderInState(orderInState), .orderOutState(orderOutState),
      .serviceConnected(serviceConnected), .secondByte(secondByte), .endServiceIn(esIn),
      .unusualEndFlag(flag), .ioIndicatorDrive(ioInd), .dataOrderIndicatorDrive(dorInd),
      .endDataDrive(endData), .channelEndDrive(chEnd), .unusualEndDrive(unEnd),
      .busyClear(busyClr));

   task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task pop_cmp(input logic [32:0] seen);
      ioss_note_s n;
      if (notes.size() == 0) begin
         fail_count++;
         $display("MISMATCH unexpected result expected none seen %h", seen);
      end else begin
         n = notes.pop_front();
         check(n.nm, seen, n.v);
      end
   endtask : pop_cmp

   // read results are judged at the pready edge, pin results on request
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) pop_cmp({pslverr, prdata});
   end
   always @(smp) pop_cmp({25'h000_0000, obs});

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   task step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] e, input string nm);
      int n;
      if (!w) notes.push_back('{nm, e});
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         $display("MISMATCH pready expected 1 seen timeout");
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task expect_pins(input string nm, input logic [7:0] e);
      @(negedge clk);
      notes.push_back('{nm, {25'h000_0000, e}});
      -> smp;
   endtask : expect_pins

   // pins take about five edges through the synchroniser, eight leaves margin
   task set_flag;
      orderInArm <= 1'b1;
      u_ioss_chan_model.term_order(1'b1);
      requestStrobe <= 1'b1;
      step(4);
      requestStrobe <= 1'b0;
      step(8);
      u_ioss_chan_model.term_order(1'b0);
      orderInArm <= 1'b0;
      step(6);
   endtask : set_flag

   task strobe(input logic [4:0] c);
      u_ioss_chan_model.instr(c, 1'b1);
      step(4);
      u_ioss_chan_model.instr(c, 1'b0);
      step(8);
   endtask : strobe

   initial begin
      step(20000);
      fail_count++;
      report_and_stop();
   end

   // obs bits: busyClr unEnd chEnd endData dor io flag irq
   initial begin
      logic [4:0] c;
      logic       a, r, p, io, data_order_line;
      void'($urandom(95173));
      step(4);
      rst_b <= 1'b1;
      step(2);
      expect_pins("pins after reset", 8'h00);
      apb(0, `IOSS_OFF_STATE, 0, 33'h0_0000_0000, "state reset");
      apb(0, `IOSS_OFF_MASK, 0, 33'h0_0000_0000, "mask reset");
      apb(0, 8'h0C, 0, 33'h1_0000_0000, "unmapped read");
      apb(1, `IOSS_OFF_MASK, 32'h0000_0007, 0, "");
      apb(0, `IOSS_OFF_MASK, 0, 33'h0_0000_0007, "mask readback");
      $display("test registers done");
      set_flag();
      expect_pins("flag set", 8'h03);
      apb(0, `IOSS_OFF_EVENT, 0, 33'h0_0000_0001, "event set");
      apb(0, `IOSS_OFF_STATE, 0, 33'h0_0000_0001, "state flag");
      serviceConnected <= 1'b1;
      orderInState     <= 1'b1;
      step(8);
      expect_pins("order in status", 8'h7B);
      u_ioss_chan_model.end_service(1'b1);
      step(8);
      expect_pins("busy clear", 8'hFB);
      u_ioss_chan_model.end_service(1'b0);
      orderInState  <= 1'b0;
      orderOutState <= 1'b1;
      step(8);
      expect_pins("order out", 8'h1F);
      orderOutState <= 1'b0;
      step(8);
      expect_pins("data in first", 8'h03);
      secondByte <= 1'b1;
      step(8);
      expect_pins("data in second", 8'h13);
      secondByte       <= 1'b0;
      serviceConnected <= 1'b0;
      apb(1, `IOSS_OFF_EVENT, 32'h0000_0001, 0, "");
      step(3);
      expect_pins("event cleared", 8'h02);
      $display("test flag set and service cycles done");
      addressMatch <= 1'b1;
      u_ioss_chan_model.instr(5'h02, 1'b0);
      functionAckDrive <= 1'b1;
      step(4);
      functionAckDrive <= 1'b0;
      step(8);
      expect_pins("halt clear", 8'h01);
      apb(0, `IOSS_OFF_EVENT, 0, 33'h0_0000_0002, "halt event");
      apb(1, `IOSS_OFF_EVENT, 32'h0000_0002, 0, "");
      set_flag();
      interruptPending <= 1'b1;
      strobe(5'h01);
      expect_pins("start refused", 8'h03);
      interruptPending <= 1'b0;
      strobe(5'h01);
      expect_pins("start clear", 8'h01);
      apb(0, `IOSS_OFF_EVENT, 0, 33'h0_0000_0005, "start event");
      apb(1, `IOSS_OFF_EVENT, 32'h0000_0007, 0, "");
      set_flag();
      sysReset <= 1'b1;
      expect_pins("system reset", 8'h01);
      step(1);
      sysReset <= 1'b0;
      apb(1, `IOSS_OFF_MASK, 32'h0000_0000, 0, "");
      step(3);
      expect_pins("masked", 8'h00);
      apb(1, `IOSS_OFF_EVENT, 32'h0000_0007, 0, "");
      $display("test flag clears done");
      for (int k = 0; k < 20; k++) begin
         c = 5'h01 << (k % 5);
         a = $urandom % 2;
         r = $urandom % 2;
         p = $urandom % 2;
         data_order_line = (a & (|c[3:0])) | c[4];
         io  = c[4] | (a & (c[3] | (c[1] & r) | ((c[2] | c[0]) & r & !p)));
         addressMatch     <= a;
         deviceReady      <= r;
         interruptPending <= p;
         u_ioss_chan_model.instr(c, 1'b1);
         step(8);
         expect_pins("indicators", {4'h0, data_order_line, io, 2'b00});
         u_ioss_chan_model.instr(c, 1'b0);
         step(6);
      end
      $display("test indicators done");
      step(4);
      report_and_stop();
   end
endmodule : tb_top
